// ===== design/sls_defs.svh
// Constants for the limit-stop and pulse-divider block.
`ifndef SLS_DEFS_SVH
`define SLS_DEFS_SVH
`define SLS_NUM_W 19
`define SLS_SPEED_W 16
`define SLS_TORQUE_W 16
`define SLS_ERR_W 32
`define SLS_STOP_SPEED_RPM 16'h001E
`define SLS_LIMIT_ALARM_NO 8'h26
`define SLS_LSEL_BOTH_ON 2'h0
`define SLS_LSEL_IGNORE 2'h1
`define SLS_LSEL_STRICT 2'h2
`define SLS_LSEL_RESET 2'h1
`define SLS_LSTOP_BRAKE 2'h0
`define SLS_LSTOP_ZERO_TQ 2'h1
`define SLS_LSTOP_IMMED 2'h2
`define SLS_SOFF_HOLD_MIN 4'h4
`define SLS_SOFF_IMMED_MIN 4'h8
`define SLS_SOFF_IMMED_UNLOCK 4'h9
`define SLS_ERR_OVF_LIMIT 32'h00FFFFFF
`define SLS_ERR_RESET 32'h00000000
`endif

// ===== design/sls_pkg.sv
// Types shared by the limit-stop and pulse-divider block.
package sls_pkg;
    typedef enum logic [2:0] {
        SLS_RUN = 3'b001,
        SLS_DECEL = 3'b010,
        SLS_STOPPED = 3'b100
    } sls_state_type;
    typedef enum logic [2:0] {
        SLS_CAUSE_NONE,
        SLS_CAUSE_LIMIT,
        SLS_CAUSE_SERVO_OFF,
        SLS_CAUSE_MAINS,
        SLS_CAUSE_ALARM
    } sls_cause_type;
    typedef enum logic [2:0] {
        SLS_ACT_RUN,
        SLS_ACT_BRAKE,
        SLS_ACT_FREE,
        SLS_ACT_IMMED,
        SLS_ACT_ZERO_TQ,
        SLS_ACT_UNLOCK
    } sls_act_type;
endpackage

// ===== design/sls_pulse_div.sv
// Encoder feedback divider producing scaled A/B/Z quadrature output.
`timescale 1ns/1ns
`include "sls_defs.svh"
module sls_pulse_div (
    input wire logic clk,
    input wire logic rst,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic enc_index,
    input wire logic [`SLS_NUM_W-1:0] numerator,
    input wire logic [`SLS_NUM_W-1:0] denominator,
    output logic out_a,
    output logic out_b,
    output logic out_z
);
    logic [`SLS_NUM_W:0] acc;
    logic [`SLS_NUM_W:0] eff_num;
    logic [`SLS_NUM_W:0] eff_den;
    logic [`SLS_NUM_W:0] sum;
    logic step;
    logic [1:0] quad;
    logic [1:0] next_quad;
    logic [19:0] rev_count;
    logic z_arm;
    logic a_rise;

    // RQ2: numerator capped at denominator.
    // A zero denominator passes feedback through one for one.
    always_comb begin
        eff_den = (denominator == '0) ? 20'h00001 : {1'b0, denominator};
        eff_num = ({1'b0, numerator} > eff_den || denominator == '0) ? eff_den : {1'b0, numerator};
        sum = acc + eff_num;
        step = enc_step && (acc < eff_den) && (sum >= eff_den);
        next_quad = enc_dir ? quad + 2'h1 : quad - 2'h1;
        a_rise = step && !quad[1] ^ 1'b0 && next_quad[1] && !out_a;
    end

    // RQ1: fractional accumulator gives num/den steps per input step.
    always_ff @(posedge clk) begin
        if (rst) begin
            acc <= '0;
        end else if (acc >= eff_den) begin
            // A smaller denominator would leave the remainder out of range and stall the output steps.
            acc <= '0;
        end else if (enc_step) begin
            acc <= step ? sum - eff_den : sum;
        end
    end

    // Gray phase counter; the outputs stay glitch free one bit per step.
    always_ff @(posedge clk) begin
        if (rst) begin
            quad <= 2'h0;
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else if (step) begin
            quad <= next_quad;
            out_a <= next_quad[1];
            out_b <= next_quad[1] ^ next_quad[0];
        end
    end

    // RQ3: one Z pulse per index mark.
    // RQ4: aligned to A only for a per-turn count divisible by four.
    always_ff @(posedge clk) begin
        if (rst) begin
            rev_count <= '0;
            z_arm <= 1'b0;
            out_z <= 1'b0;
        end else if (enc_index) begin
            rev_count <= '0;
            z_arm <= (rev_count[1:0] == 2'h0) && (rev_count != '0);
            out_z <= !((rev_count[1:0] == 2'h0) && (rev_count != '0));
        end else begin
            rev_count <= step ? rev_count + 20'h00001 : rev_count;
            if (z_arm && a_rise) begin
                z_arm <= 1'b0;
                out_z <= 1'b1;
            end else if (out_z && !z_arm && (enc_step && !out_a ? 1'b1 : step && !next_quad[1])) begin
                out_z <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // RQ2: never more output steps than feedback steps.
    div_no_excess_a: assert property (!enc_step |=> $stable(quad)) // RQ2
        else $error("Output step without feedback step.");
    // RQ3: Z only starts at an index or an armed A edge.
    z_start_a: assert property ($rose(out_z) |-> $past(enc_index) || $past(z_arm)) // RQ3
        else $error("Z pulse without index.");
    cover_z_aligned_c: cover property (z_arm ##[1:50] $rose(out_z));
endmodule

// ===== design/sls_stop_ctrl.sv
// Limit monitor, stop sequencer and divided pulse output of a servo drive.
// Notes on behaviour
// RQ1: Output pulses equal feedback times numerator/denominator.
// RQ2: Never exceed encoder resolution per turn.
// RQ3: Exactly one Z pulse per revolution.
// RQ4: Z aligned to A when count multiple of four.
// RQ5: Limit select 0,2 enable; 1 ignores.
// RQ6: Select 0: open limit blocks its direction.
// RQ7: Select 0: both open raises alarm 38.
// RQ8: Select 2: either open raises alarm 38.
// RQ9: Select 0: limit hit decelerates and stops.
// RQ10: Limit stop 0: brake, zero torque, hold.
// RQ11: Limit stop 1: zero torque throughout, hold.
// RQ12: Limit stop 2: immediate stop, clear counter.
// RQ13: Servo-off select picks braking and after-stop state.
// RQ14: Servo-off 0-3,8,9 clear; 4-7 hold errors.
// RQ15: Held errors keep accumulating, may overflow.
// RQ16: Deceleration ends at 30 r/min or less.
// RQ17: Immediate stop keeps loop, clamps torque.
// RQ18: Alarm or mains-off use their own tables.
// RQ19: Return to running only on servo-on again.
`timescale 1ns/1ns
`include "sls_defs.svh"
module sls_stop_ctrl
    import sls_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic ENC_STEP,
    input wire logic ENC_DIR,
    input wire logic ENC_INDEX,
    input wire logic CMD_STEP,
    input wire logic CMD_DIR,
    input wire logic [`SLS_NUM_W-1:0] OUTPUT_PULSE_NUMERATOR,
    input wire logic [`SLS_NUM_W-1:0] DIVIDER_DENOMINATOR,
    input wire logic [1:0] LIMIT_INPUT_SELECT,
    input wire logic [1:0] LIMIT_STOP_SELECT,
    input wire logic [3:0] SERVO_OFF_STOP_SELECT,
    input wire logic [3:0] MAINS_OFF_STOP_SELECT,
    input wire logic [2:0] ALARM_STOP_SELECT,
    input wire logic [`SLS_TORQUE_W-1:0] IMMEDIATE_STOP_TORQUE,
    input wire logic FORWARD_LIMIT_INPUT,
    input wire logic REVERSE_LIMIT_INPUT,
    input wire logic SERVO_ON,
    input wire logic ALARM_IN,
    input wire logic MAINS_OFF,
    input wire logic [`SLS_SPEED_W-1:0] MOTOR_SPEED,
    input wire logic signed [`SLS_TORQUE_W-1:0] TORQUE_CMD_IN,
    output logic OUT_A,
    output logic OUT_B,
    output logic OUT_Z,
    output logic LIMIT_INPUT_ERROR,
    output logic [7:0] ALARM_NUMBER,
    output logic FORWARD_BLOCKED,
    output logic REVERSE_BLOCKED,
    output logic [2:0] STOP_STATE,
    output logic DYNAMIC_BRAKE,
    output logic SERVO_ACTIVE,
    output logic signed [`SLS_TORQUE_W-1:0] TORQUE_CMD_OUT,
    output logic CLEAR_ERROR_COUNTER,
    output logic signed [`SLS_ERR_W-1:0] POSITION_ERROR,
    output logic COUNTER_OVERFLOW_ERROR
);
    sls_state_type state;
    sls_state_type next_state;
    sls_cause_type cause;
    sls_cause_type next_cause;
    sls_act_type decel_act;
    sls_act_type after_act;
    sls_act_type next_decel_act;
    sls_act_type next_after_act;
    sls_act_type cur_act;
    logic clear_sel;
    logic next_clear_sel;
    logic servo_on_q;
    logic servo_on_rise;
    logic fwd_open;
    logic rev_open;
    logic fwd_blk;
    logic rev_blk;
    logic limit_err;
    logic alarm_any;
    logic slow;
    logic [3:0] off_sel;
    logic signed [`SLS_TORQUE_W-1:0] tq_lim;
    logic signed [`SLS_TORQUE_W-1:0] next_torque;
    logic signed [`SLS_ERR_W-1:0] next_pos_err;
    logic [`SLS_ERR_W-1:0] err_mag;

    // The divided pulse output lives in its own module.
    sls_pulse_div u_div (
        .clk(CLK),
        .rst(RST),
        .enc_step(ENC_STEP),
        .enc_dir(ENC_DIR),
        .enc_index(ENC_INDEX),
        .numerator(OUTPUT_PULSE_NUMERATOR),
        .denominator(DIVIDER_DENOMINATOR),
        .out_a(OUT_A),
        .out_b(OUT_B),
        .out_z(OUT_Z)
    );

    // A limit input reads high while its switch connects it to common.
    // RQ5: select 1 masks both inputs.
    always_comb begin
        fwd_open = !FORWARD_LIMIT_INPUT && (LIMIT_INPUT_SELECT != `SLS_LSEL_IGNORE);
        rev_open = !REVERSE_LIMIT_INPUT && (LIMIT_INPUT_SELECT != `SLS_LSEL_IGNORE);
        // RQ6: only select 0 blocks one direction.
        fwd_blk = fwd_open && (LIMIT_INPUT_SELECT == `SLS_LSEL_BOTH_ON);
        rev_blk = rev_open && (LIMIT_INPUT_SELECT == `SLS_LSEL_BOTH_ON);
        // RQ7: both open under select 0.
        // RQ8: either open under select 2.
        limit_err = (fwd_blk && rev_blk)
            || ((LIMIT_INPUT_SELECT == `SLS_LSEL_STRICT) && (fwd_open || rev_open));
        alarm_any = ALARM_IN || limit_err;
        // RQ16: stop threshold in r/min.
        slow = MOTOR_SPEED <= `SLS_STOP_SPEED_RPM;
        servo_on_rise = SERVO_ON && !servo_on_q;
    end

    // Limit status is registered so every top output leaves a flip-flop.
    always_ff @(posedge CLK) begin
        if (RST) begin
            servo_on_q <= 1'b0;
            LIMIT_INPUT_ERROR <= 1'b0;
            ALARM_NUMBER <= 8'h00;
            FORWARD_BLOCKED <= 1'b0;
            REVERSE_BLOCKED <= 1'b0;
        end else begin
            servo_on_q <= SERVO_ON;
            LIMIT_INPUT_ERROR <= limit_err;
            ALARM_NUMBER <= limit_err ? `SLS_LIMIT_ALARM_NO : 8'h00;
            FORWARD_BLOCKED <= fwd_blk;
            REVERSE_BLOCKED <= rev_blk;
        end
    end

    // RQ18: alarm outranks mains-off, which outranks servo-off and limits.
    // A stop already under way moves to a higher-ranked table when one appears.
    always_comb begin
        next_state = state;
        next_cause = cause;
        if (alarm_any && cause != SLS_CAUSE_ALARM) begin
            next_cause = SLS_CAUSE_ALARM;
        end else if (MAINS_OFF && (cause == SLS_CAUSE_NONE || cause == SLS_CAUSE_SERVO_OFF
            || cause == SLS_CAUSE_LIMIT)) begin
            next_cause = SLS_CAUSE_MAINS;
        end else if (!SERVO_ON && (cause == SLS_CAUSE_NONE || cause == SLS_CAUSE_LIMIT)) begin
            next_cause = SLS_CAUSE_SERVO_OFF;
        end else if ((fwd_blk || rev_blk) && cause == SLS_CAUSE_NONE) begin
            // RQ9: limit hit starts a stop.
            next_cause = SLS_CAUSE_LIMIT;
        end
        unique case (state)
            SLS_RUN: begin
                if (next_cause != SLS_CAUSE_NONE) begin
                    next_state = SLS_DECEL;
                end
            end
            SLS_DECEL: begin
                // RQ16: end of deceleration.
                if (next_cause != cause) begin
                    next_state = SLS_DECEL;
                end else if (slow) begin
                    next_state = SLS_STOPPED;
                end
            end
            SLS_STOPPED: begin
                // RQ16: stays stopped whatever the speed.
                // RQ19: restart needs a fresh servo-on.
                if (next_cause != cause) begin
                    next_state = SLS_DECEL;
                end else if (servo_on_rise && !alarm_any && !MAINS_OFF
                    && !fwd_blk && !rev_blk) begin
                    next_state = SLS_RUN;
                    next_cause = SLS_CAUSE_NONE;
                end
            end
        endcase
    end

    // Stop tables for the cause being entered.
    always_comb begin
        off_sel = (next_cause == SLS_CAUSE_MAINS) ? MAINS_OFF_STOP_SELECT : SERVO_OFF_STOP_SELECT;
        next_decel_act = SLS_ACT_BRAKE;
        next_after_act = SLS_ACT_BRAKE;
        next_clear_sel = 1'b1;
        unique case (next_cause)
            SLS_CAUSE_LIMIT: begin
                // RQ10: brake, then zero torque, hold.
                // RQ11: zero torque throughout, hold.
                // RQ12: immediate stop, clear throughout.
                next_decel_act = (LIMIT_STOP_SELECT == `SLS_LSTOP_IMMED) ? SLS_ACT_IMMED
                    : (LIMIT_STOP_SELECT == `SLS_LSTOP_ZERO_TQ) ? SLS_ACT_ZERO_TQ
                    : SLS_ACT_BRAKE;
                next_after_act = SLS_ACT_ZERO_TQ;
                next_clear_sel = LIMIT_STOP_SELECT == `SLS_LSTOP_IMMED;
            end
            SLS_CAUSE_SERVO_OFF, SLS_CAUSE_MAINS: begin
                // RQ13: even brakes, odd free-runs, 8 and 9 stop at once.
                next_decel_act = (off_sel >= `SLS_SOFF_IMMED_MIN) ? SLS_ACT_IMMED
                    : off_sel[0] ? SLS_ACT_FREE : SLS_ACT_BRAKE;
                next_after_act = ((off_sel == `SLS_SOFF_IMMED_UNLOCK)
                    || (off_sel < `SLS_SOFF_IMMED_MIN && off_sel[1]))
                    ? SLS_ACT_UNLOCK : SLS_ACT_BRAKE;
                // RQ14: clear or hold by range.
                next_clear_sel = (off_sel < `SLS_SOFF_HOLD_MIN) || (off_sel >= `SLS_SOFF_IMMED_MIN);
            end
            SLS_CAUSE_ALARM: begin
                // Upper half stops at once, bit 1 unlocks after stopping.
                next_decel_act = ALARM_STOP_SELECT[2] ? SLS_ACT_IMMED
                    : ALARM_STOP_SELECT[0] ? SLS_ACT_FREE : SLS_ACT_BRAKE;
                next_after_act = ALARM_STOP_SELECT[1] ? SLS_ACT_UNLOCK : SLS_ACT_BRAKE;
                next_clear_sel = 1'b1;
            end
            default: begin
                next_decel_act = SLS_ACT_RUN;
                next_after_act = SLS_ACT_RUN;
                next_clear_sel = 1'b0;
            end
        endcase
    end

    // The table is latched on entry so a later select change waits for the next stop.
    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= SLS_RUN;
            cause <= SLS_CAUSE_NONE;
            decel_act <= SLS_ACT_RUN;
            after_act <= SLS_ACT_RUN;
            clear_sel <= 1'b0;
        end else begin
            state <= next_state;
            cause <= next_cause;
            if (next_cause != cause) begin
                decel_act <= next_decel_act;
                after_act <= next_after_act;
                clear_sel <= next_clear_sel;
            end
        end
    end

    // Output action of the present phase, and the clamped torque.
    always_comb begin
        cur_act = (state == SLS_DECEL) ? decel_act
            : (state == SLS_STOPPED) ? after_act : SLS_ACT_RUN;
        // The magnitude saturates so that its negation stays representable.
        tq_lim = IMMEDIATE_STOP_TORQUE[15] ? 16'sh7FFF : $signed(IMMEDIATE_STOP_TORQUE);
        next_torque = TORQUE_CMD_IN;
        unique case (cur_act)
            SLS_ACT_RUN: next_torque = TORQUE_CMD_IN;
            SLS_ACT_IMMED: begin
                // RQ17: clamp to the stop torque.
                if (TORQUE_CMD_IN > tq_lim) begin
                    next_torque = tq_lim;
                end else if (TORQUE_CMD_IN < -tq_lim) begin
                    next_torque = -tq_lim;
                end
            end
            SLS_ACT_ZERO_TQ: begin
                // Torque towards a blocked side is dropped; the free side stays.
                if ((fwd_blk && TORQUE_CMD_IN > 0) || (rev_blk && TORQUE_CMD_IN < 0)) begin
                    next_torque = '0;
                end
            end
            default: next_torque = '0;
        endcase
    end

    // Drive stage outputs.
    always_ff @(posedge CLK) begin
        if (RST) begin
            STOP_STATE <= SLS_RUN;
            DYNAMIC_BRAKE <= 1'b0;
            SERVO_ACTIVE <= 1'b0;
            TORQUE_CMD_OUT <= '0;
            CLEAR_ERROR_COUNTER <= 1'b0;
        end else begin
            STOP_STATE <= state;
            DYNAMIC_BRAKE <= cur_act == SLS_ACT_BRAKE;
            // RQ17: the loop stays closed during an immediate stop.
            SERVO_ACTIVE <= cur_act == SLS_ACT_RUN || cur_act == SLS_ACT_IMMED
                || cur_act == SLS_ACT_ZERO_TQ;
            TORQUE_CMD_OUT <= next_torque;
            CLEAR_ERROR_COUNTER <= state != SLS_RUN && clear_sel;
        end
    end

    // RQ15: the counter keeps running while held, so it can overflow.
    always_comb begin
        next_pos_err = POSITION_ERROR;
        if (CMD_STEP) begin
            next_pos_err = CMD_DIR ? next_pos_err + 1 : next_pos_err - 1;
        end
        if (ENC_STEP) begin
            next_pos_err = ENC_DIR ? next_pos_err - 1 : next_pos_err + 1;
        end
        err_mag = POSITION_ERROR[`SLS_ERR_W-1] ? -POSITION_ERROR : POSITION_ERROR;
    end

    // RQ14: clearing wins over accumulation.
    // The overflow flag is sticky until reset so a short excursion is not missed.
    always_ff @(posedge CLK) begin
        if (RST) begin
            POSITION_ERROR <= `SLS_ERR_RESET;
            COUNTER_OVERFLOW_ERROR <= 1'b0;
        end else begin
            POSITION_ERROR <= (state != SLS_RUN && clear_sel) ? `SLS_ERR_RESET : next_pos_err;
            if (err_mag > `SLS_ERR_OVF_LIMIT) begin
                COUNTER_OVERFLOW_ERROR <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    ign_sel1_a: assert property (LIMIT_INPUT_SELECT == `SLS_LSEL_IGNORE |=> !LIMIT_INPUT_ERROR && !FORWARD_BLOCKED && !REVERSE_BLOCKED) // RQ5
        else $error("Limit inputs not ignored.");
    fwd_block_a: assert property (LIMIT_INPUT_SELECT == `SLS_LSEL_BOTH_ON && !FORWARD_LIMIT_INPUT && REVERSE_LIMIT_INPUT |=> FORWARD_BLOCKED && !REVERSE_BLOCKED) // RQ6
        else $error("Forward limit did not block forward only.");
    both_open_a: assert property (LIMIT_INPUT_SELECT == `SLS_LSEL_BOTH_ON && !FORWARD_LIMIT_INPUT && !REVERSE_LIMIT_INPUT |=> LIMIT_INPUT_ERROR && ALARM_NUMBER == 8'h26) // RQ7
        else $error("Both limits open without alarm.");
    strict_open_a: assert property (LIMIT_INPUT_SELECT == `SLS_LSEL_STRICT && (!FORWARD_LIMIT_INPUT || !REVERSE_LIMIT_INPUT) |=> LIMIT_INPUT_ERROR) // RQ8
        else $error("Strict limit open without alarm.");
    limit_start_a: assert property (state == SLS_RUN && SERVO_ON && !ALARM_IN && !MAINS_OFF && !limit_err && (fwd_blk || rev_blk) |=> state == SLS_DECEL && cause == SLS_CAUSE_LIMIT) // RQ9
        else $error("Limit hit did not start a stop.");
    limit_brake_a: assert property (state == SLS_DECEL && cause == SLS_CAUSE_LIMIT && decel_act == SLS_ACT_BRAKE |=> DYNAMIC_BRAKE && !CLEAR_ERROR_COUNTER) // RQ10
        else $error("Limit stop 0 not braking with hold.");
    limit_zero_a: assert property (cause == SLS_CAUSE_LIMIT && state == SLS_STOPPED && fwd_blk && TORQUE_CMD_IN > 0 |=> TORQUE_CMD_OUT == 0 && SERVO_ACTIVE) // RQ11
        else $error("Prohibited torque not zeroed.");
    limit_clear_a: assert property (state == SLS_DECEL && cause == SLS_CAUSE_LIMIT && clear_sel |=> CLEAR_ERROR_COUNTER ##1 POSITION_ERROR == 0) // RQ12
        else $error("Limit stop 2 did not clear.");
    soff_free_a: assert property (state == SLS_DECEL && cause == SLS_CAUSE_SERVO_OFF && decel_act == SLS_ACT_FREE |=> !DYNAMIC_BRAKE && !SERVO_ACTIVE) // RQ13
        else $error("Free-run still drives the motor.");
    soff_hold_a: assert property (state == SLS_RUN && !SERVO_ON && !alarm_any && !MAINS_OFF && SERVO_OFF_STOP_SELECT inside {[4:7]} |=> ##1 !CLEAR_ERROR_COUNTER) // RQ14
        else $error("Held error counter was cleared.");
    hold_count_a: assert property (state != SLS_RUN && !clear_sel && CMD_STEP && CMD_DIR && !ENC_STEP |=> POSITION_ERROR == $past(POSITION_ERROR) + 1) // RQ15
        else $error("Held counter stopped accumulating.");
    decel_end_a: assert property (state == SLS_DECEL && slow && next_cause == cause |=> state == SLS_STOPPED) // RQ16
        else $error("Deceleration did not end at low speed.");
    immed_clamp_a: assert property (cur_act == SLS_ACT_IMMED |=> TORQUE_CMD_OUT <= $past(tq_lim) && TORQUE_CMD_OUT >= -$past(tq_lim) && SERVO_ACTIVE) // RQ17
        else $error("Immediate stop torque not clamped.");
    alarm_rank_a: assert property (state != SLS_RUN && cause == SLS_CAUSE_SERVO_OFF && ALARM_IN |=> cause == SLS_CAUSE_ALARM) // RQ18
        else $error("Alarm table not taken.");
    restart_a: assert property (state == SLS_STOPPED && !servo_on_rise |=> state != SLS_RUN) // RQ19
        else $error("Restart without fresh servo-on.");

    cover_limit_c: cover property (state == SLS_RUN ##1 cause == SLS_CAUSE_LIMIT ##[1:50] state == SLS_STOPPED);
    cover_soff_c: cover property (cause == SLS_CAUSE_SERVO_OFF && state == SLS_STOPPED ##[1:50] state == SLS_RUN);
    cover_alarm_c: cover property (cause == SLS_CAUSE_ALARM && cur_act == SLS_ACT_IMMED);
endmodule

// ===== test/sls_enc_model.sv
// Encoder model: bursts of feedback counts, tallies divided output steps.
`timescale 1ns/1ns
module sls_enc_model (
    input wire logic clk,
    input wire logic start,
    input wire logic [7:0] count,
    input wire logic out_a,
    input wire logic out_b,
    output logic enc_step = 1'b0,
    output logic enc_index = 1'b0,
    output logic busy,
    output int seen = 0
);
    logic [7:0] left = 8'h00;
    logic [5:0] pos = 6'h00;
    logic pa = 1'b0;
    logic pb = 1'b0;
    assign busy = left != 8'h00;
    // One count every other cycle; index rides on every 64th count.
    always @(posedge clk) begin
        pa <= out_a;
        pb <= out_b;
        seen <= start ? 0 : seen + int'(out_a != pa) + int'(out_b != pb);
        enc_step <= !enc_step && busy;
        enc_index <= !enc_step && busy && pos == 6'h3F;
        if (start) begin
            left <= count;
        end else if (enc_step) begin
            left <= left - 8'h01;
            pos <= pos + 6'h01;
        end
    end
endmodule

// ===== test/test_servo_limit_stop_and_pulse_divider.sv
// Self-checking bench for the limit monitor, stop sequencer and divider.
`timescale 1ns/1ns
`include "sls_defs.svh"
module test_servo_limit_stop_and_pulse_divider;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic ENC_STEP, ENC_INDEX, busy, OUT_A, OUT_B, OUT_Z, LIMIT_INPUT_ERROR;
    logic FORWARD_BLOCKED, REVERSE_BLOCKED, DYNAMIC_BRAKE, SERVO_ACTIVE;
    logic CLEAR_ERROR_COUNTER, COUNTER_OVERFLOW_ERROR;
    logic ENC_DIR = 1'b1;
    logic CMD_STEP = 1'b0;
    logic CMD_DIR = 1'b1;
    logic ALARM_IN = 1'b0;
    logic MAINS_OFF = 1'b0;
    logic SERVO_ON = 1'b1;
    logic FORWARD_LIMIT_INPUT = 1'b1;
    logic REVERSE_LIMIT_INPUT = 1'b1;
    logic start = 1'b0;
    logic [7:0] count = 8'h40;
    logic [1:0] LIMIT_INPUT_SELECT = 2'h1;
    logic [1:0] LIMIT_STOP_SELECT = 2'h0;
    logic [3:0] SERVO_OFF_STOP_SELECT = 4'h0;
    logic [3:0] MAINS_OFF_STOP_SELECT = 4'h0;
    logic [2:0] ALARM_STOP_SELECT = 3'h0;
    logic [`SLS_NUM_W-1:0] OUTPUT_PULSE_NUMERATOR = 19'h00001;
    logic [`SLS_NUM_W-1:0] DIVIDER_DENOMINATOR = 19'h00000;
    logic [15:0] MOTOR_SPEED = 16'h000A;
    logic [15:0] IMMEDIATE_STOP_TORQUE = 16'h0000;
    logic signed [15:0] TORQUE_CMD_IN = 16'h0000;
    logic signed [15:0] TORQUE_CMD_OUT;
    logic signed [31:0] POSITION_ERROR;
    logic [7:0] ALARM_NUMBER;
    logic [2:0] STOP_STATE;
    int error_cnt = 0;
    int check_count = 0;
    int seen, perr, den, num, e, tq;
    // Free-running 100 MHz clock.
    always #5 CLK = ~CLK;
    sls_stop_ctrl u_dut (.*);
    sls_enc_model u_enc (.clk(CLK), .start(start), .count(count), .out_a(OUT_A), .out_b(OUT_B),
        .enc_step(ENC_STEP), .enc_index(ENC_INDEX), .busy(busy), .seen(seen));
    // Reads see values from before the edge, so settled outputs only.
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence: limits, servo-off tables, then the divider.
    initial begin
        void'($urandom(32'hC8E058E9));
        MAINS_OFF_STOP_SELECT = 4'($urandom % 10);
        ALARM_STOP_SELECT = 3'($urandom);
        IMMEDIATE_STOP_TORQUE = 16'($urandom % 32768);
        TORQUE_CMD_IN = 16'($urandom);
        tick(5);
        RST <= 1'b0;
        tick(3);
        for (int s = 0; s < 3; s++) begin
            for (int p = 0; p < 4; p++) begin
                LIMIT_INPUT_SELECT <= 2'(s);
                LIMIT_STOP_SELECT <= 2'($urandom % 3);
                FORWARD_LIMIT_INPUT <= p[0];
                REVERSE_LIMIT_INPUT <= p[1];
                tick(3);
                e = (s == 0 && p == 0) || (s == 2 && p != 3);
                chk(LIMIT_INPUT_ERROR, e, "limit error");
                chk(ALARM_NUMBER, e ? 38 : 0, "alarm no");
                chk(FORWARD_BLOCKED, s == 0 && !p[0], "fwd block");
                chk(REVERSE_BLOCKED, s == 0 && !p[1], "rev block");
            end
        end
        LIMIT_INPUT_SELECT <= 2'h1;
        SERVO_ON <= 1'b0;
        tick(4);
        SERVO_ON <= 1'b1;
        tick(4);
        perr = 0;
        $display("limit test done");
        for (int s = 0; s < 10; s++) begin
            chk(STOP_STATE, 3'b001, "running");
            SERVO_OFF_STOP_SELECT <= 4'(s);
            MOTOR_SPEED <= 16'h0064;
            SERVO_ON <= 1'b0;
            tick(3);
            chk(STOP_STATE, 3'b010, "decel");
            chk(DYNAMIC_BRAKE, s < 8 && s % 2 == 0, "decel brake");
            chk(SERVO_ACTIVE, s > 7, "immediate");
            chk(CLEAR_ERROR_COUNTER, s < 4 || s > 7, "clear");
            tq = IMMEDIATE_STOP_TORQUE;
            e = s < 8 ? 0 : TORQUE_CMD_IN > tq ? tq : TORQUE_CMD_IN < -tq ? -tq : TORQUE_CMD_IN;
            chk(TORQUE_CMD_OUT, e, "torque");
            MOTOR_SPEED <= 16'h001E;
            tick(3);
            MOTOR_SPEED <= 16'h0064;
            repeat (5) begin
                CMD_STEP <= 1'b1;
                tick(1);
                CMD_STEP <= 1'b0;
                tick(1);
            end
            perr = (s < 4 || s > 7) ? 0 : perr + 5;
            tick(2);
            chk(STOP_STATE, 3'b100, "stopped");
            chk(DYNAMIC_BRAKE, s == 8 || (s < 8 && s % 4 < 2), "stop brake");
            chk(POSITION_ERROR, perr, "pos error");
            if (s == 5) begin
                ALARM_IN <= 1'b1;
                MOTOR_SPEED <= 16'h000A;
                tick(3);
                chk(STOP_STATE, 3'b010, "alarm decel");
                chk(CLEAR_ERROR_COUNTER, 1, "alarm clear");
                ALARM_IN <= 1'b0;
                tick(2);
                perr = 0;
            end
            SERVO_ON <= 1'b1;
            MOTOR_SPEED <= 16'h000A;
            tick(3);
        end
        $display("servo-off test done");
        for (int i = 0; i < 4; i++) begin
            den = (i == 3) ? 0 : 1 << ($urandom % 5);
            num = (i == 3) ? 1 + $urandom % 16 : (i == 2) ? den + 5 : 1 + $urandom % den;
            OUTPUT_PULSE_NUMERATOR <= 19'(num);
            DIVIDER_DENOMINATOR <= 19'(den);
            tick(2);
            start <= 1'b1;
            tick(1);
            start <= 1'b0;
            tick(2);
            e = 0;
            while (busy !== 1'b0 && e < 1000) begin
                tick(1);
                e++;
            end
            if (e == 1000) begin
                error_cnt++;
                $display("BAD t=%0t encoder burst hung", $time);
                wrap_up();
            end
            tick(4);
            perr -= 64;
            chk(seen, den == 0 ? 64 : 64 * (num > den ? den : num) / den, "steps");
            chk(POSITION_ERROR, perr, "pos error");
        end
        $display("divider test done");
        chk(COUNTER_OVERFLOW_ERROR, 0, "overflow");
        wrap_up();
    end
endmodule
